//--- logic/dso_cfg.svh
// Offsets, codes, reset values and timing of the drive status block
`ifndef DSO_CFG_SVH
`define DSO_CFG_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DSO_SRC_SEL_OFF   8'h00
`define DSO_OUT_SEL_OFF   8'h04
`define DSO_CHK_EN_OFF    8'h08
`define DSO_INIT_CFG_OFF  8'h0C
`define DSO_INIT_TRG_OFF  8'h10
`define DSO_STATUS_OFF    8'h14
`define DSO_IRQ_STAT_OFF  8'h18
`define DSO_IRQ_MASK_OFF  8'h1C
`define DSO_SPAN_CAL_OFF  8'h20
`define DSO_TRIP_CNT_OFF  8'h24
`define DSO_RUN_TIME_OFF  8'h28
`define DSO_PON_TIME_OFF  8'h2C

// ----------------------------------------
// Codes
// ----------------------------------------
`define DSO_CODE_00       8'h00
`define DSO_CODE_01       8'h01
`define DSO_CODE_02       8'h02
`define DSO_CODE_03       8'h03
`define DSO_FUNC_FREQ     8'h3A
`define DSO_FUNC_RUN      8'h3B
`define DSO_FUNC_SM       8'h3C
// Phase loss window, output frequency in 0.01 Hz units
`define DSO_PL_LO         16'd500
`define DSO_PL_HI         16'd10000

// ----------------------------------------
// Reset and factory default values
// ----------------------------------------
`define DSO_FSRC_DEF0     8'h02
`define DSO_FSRC_DEF1     8'h00
`define DSO_RSRC_DEF0     8'h02
`define DSO_RSRC_DEF1     8'h01
`define DSO_TERM_DEF      8'h00
`define DSO_RELAY_DEF     8'h00
`define DSO_CHK_DEF       8'h01

// ----------------------------------------
// Timing
// ----------------------------------------
`define DSO_CLK_MHZ       50
`define DSO_INIT_SHOW_MS  2000
`define DSO_TICK_MS       1000
`define DSO_INIT_CYC      (`DSO_INIT_SHOW_MS * `DSO_CLK_MHZ * 1000)
`define DSO_TICK_CYC      (`DSO_TICK_MS * `DSO_CLK_MHZ * 1000)

`endif

//--- logic/dso_pkg.sv
// Types shared by the drive status block
package dso_pkg;

	// ----------------------------------------
	// Initialisation sequencer states
	// ----------------------------------------
	typedef enum logic [2:0] {
		DSO_IDLE = 3'b001,
		DSO_APPLY = 3'b010,
		DSO_SHOW = 3'b100
	} dso_state_e;

	// ----------------------------------------
	// Initialisation setup
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] region;
		logic [7:0] target;
		logic [7:0] mode;
	} dso_init_s;

	// ----------------------------------------
	// Indication outputs
	// ----------------------------------------
	typedef struct packed {
		logic second_motor;
		logic run_src;
		logic freq_src;
	} dso_ind_s;

endpackage

//--- logic/dso_status_init.sv
// Drive status outputs, check enables and parameter initialisation
`include "dso_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module dso_status_init #(
	parameter int INIT_CYC = `DSO_INIT_CYC,
	parameter int TICK_CYC = `DSO_TICK_CYC
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	input  wire logic        second_motor_sel_pin,
	input  wire logic [15:0] output_freq,
	input  wire logic        run_active,
	input  wire logic        trip_event,
	output logic             freq_ref_source_ind,
	output logic             run_cmd_source_ind,
	output logic             second_motor_active_ind,
	output logic             term_out,
	output logic             relay_out,
	output logic             ground_fault_check_start,
	output logic             phase_loss_check_active,
	output logic             init_busy,
	output logic             irq
);

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0]        freq_source_select;      // Frequency source code
	logic [7:0]        run_cmd_source_select;   // Run command source code
	logic [7:0]        output_terminal_func_sel; // Terminal function
	logic [7:0]        relay_func_sel;          // Relay function
	logic [7:0]        ground_fault_check_en;   // 00 off, 01 on
	logic [7:0]        phase_loss_check_en;     // 00 off, 01 on
	dso_pkg::dso_init_s init_cfg_reg;           // Mode, target, region
	logic [7:0]        init_trigger;            // 01 starts a run
	logic [15:0]       analog_span_cal;         // Never restored
	logic [15:0]       trip_cnt_reg;            // Trip history depth
	logic [31:0]       run_time_reg;            // Seconds while running
	logic [31:0]       pon_time_reg;            // Seconds since power-up
	logic [2:0]        irq_stat_reg;            // Sticky events
	logic [2:0]        irq_mask_reg;            // Enables per event
	dso_pkg::dso_state_e state_reg;             // Sequencer state
	logic [31:0]       show_cnt_reg;            // Busy display timer
	logic [31:0]       tick_cnt_reg;            // One second divider
	logic              tick;                    // One second pulse
	logic              sm_meta_reg;             // Synchroniser stage 1
	logic              sm_sync_reg;             // Synchroniser stage 2
	logic              sm_prev_reg;             // For edge detect
	logic              pon_pend_reg;            // Power-up check pending
	dso_pkg::dso_ind_s ind;                     // Indication set
	logic              init_done;               // Sequence end pulse

	// ----------------------------------------
	// Bus address phase capture
	// ----------------------------------------
	logic        dp_wr_reg;   // Write pending in data phase
	logic [7:0]  dp_addr_reg; // Its word offset
	logic        ap_valid;    // Accepted address phase
	logic [31:0] rd_mux;      // Read value selected

	assign ap_valid = hsel && hready && htrans[1];
	// Zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// Latch write intent for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dp_wr_reg <= 1'b0;
			dp_addr_reg <= 8'h00;
		end else begin
			dp_wr_reg <= ap_valid && hwrite;
			dp_addr_reg <= {haddr[7:2], 2'b00};
		end
	end

	logic wr_src, wr_out, wr_chk, wr_cfg, wr_trg;
	logic wr_stat, wr_mask, wr_cal;
	assign wr_src = dp_wr_reg && dp_addr_reg == `DSO_SRC_SEL_OFF;
	assign wr_out = dp_wr_reg && dp_addr_reg == `DSO_OUT_SEL_OFF;
	assign wr_chk = dp_wr_reg && dp_addr_reg == `DSO_CHK_EN_OFF;
	assign wr_cfg = dp_wr_reg && dp_addr_reg == `DSO_INIT_CFG_OFF;
	assign wr_trg = dp_wr_reg && dp_addr_reg == `DSO_INIT_TRG_OFF;
	assign wr_stat = dp_wr_reg && dp_addr_reg == `DSO_IRQ_STAT_OFF;
	assign wr_mask = dp_wr_reg && dp_addr_reg == `DSO_IRQ_MASK_OFF;
	assign wr_cal = dp_wr_reg && dp_addr_reg == `DSO_SPAN_CAL_OFF;

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Registered so data stands through the data phase
	always_comb begin
		case ({haddr[7:2], 2'b00})
			`DSO_SRC_SEL_OFF:
				rd_mux = {16'h0000, run_cmd_source_select,
					freq_source_select};
			`DSO_OUT_SEL_OFF:
				rd_mux = {16'h0000, relay_func_sel,
					output_terminal_func_sel};
			`DSO_CHK_EN_OFF:
				rd_mux = {16'h0000, phase_loss_check_en,
					ground_fault_check_en};
			`DSO_INIT_CFG_OFF: rd_mux = {8'h00, init_cfg_reg};
			`DSO_INIT_TRG_OFF: rd_mux = {24'h0000_00, init_trigger};
			`DSO_STATUS_OFF:
				rd_mux = {26'h000_0000, init_busy,
					phase_loss_check_active, pon_pend_reg, ind};
			`DSO_IRQ_STAT_OFF: rd_mux = {29'h0000_0000, irq_stat_reg};
			`DSO_IRQ_MASK_OFF: rd_mux = {29'h0000_0000, irq_mask_reg};
			`DSO_SPAN_CAL_OFF: rd_mux = {16'h0000, analog_span_cal};
			`DSO_TRIP_CNT_OFF: rd_mux = {16'h0000, trip_cnt_reg};
			`DSO_RUN_TIME_OFF: rd_mux = run_time_reg;
			`DSO_PON_TIME_OFF: rd_mux = pon_time_reg;
			default: rd_mux = 32'h0000_0000; // Unmapped reads zero
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata <= 32'h0000_0000;
		else if (ap_valid && !hwrite)
			hrdata <= rd_mux;
	end

	// ----------------------------------------
	// Second motor select input
	// ----------------------------------------
	// Pin is asynchronous; two stages before use
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sm_meta_reg <= 1'b0;
			sm_sync_reg <= 1'b0;
			sm_prev_reg <= 1'b0;
		end else begin
			sm_meta_reg <= second_motor_sel_pin;
			sm_sync_reg <= sm_meta_reg;
			sm_prev_reg <= sm_sync_reg;
		end
	end

	// ----------------------------------------
	// Indications and output routing
	// ----------------------------------------
	// Second control mode masks both source flags
	// One driver for the whole set: second motor, run, frequency
	assign ind = {sm_sync_reg,
		(run_cmd_source_select == `DSO_CODE_02) && !sm_sync_reg,
		(freq_source_select == `DSO_CODE_02) && !sm_sync_reg};

	// Selects one indication by function code
	function automatic logic route(input logic [7:0] code,
		input dso_pkg::dso_ind_s s);
		case (code)
			`DSO_FUNC_FREQ: route = s.freq_src;
			`DSO_FUNC_RUN: route = s.run_src;
			`DSO_FUNC_SM: route = s.second_motor;
			default: route = 1'b0;
		endcase
	endfunction

	// Outputs from flip-flops, one cycle behind
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			freq_ref_source_ind <= 1'b0;
			run_cmd_source_ind <= 1'b0;
			second_motor_active_ind <= 1'b0;
			term_out <= 1'b0;
			relay_out <= 1'b0;
			phase_loss_check_active <= 1'b0;
		end else begin
			freq_ref_source_ind <= ind.freq_src;
			run_cmd_source_ind <= ind.run_src;
			second_motor_active_ind <= ind.second_motor;
			term_out <= route(output_terminal_func_sel, ind);
			relay_out <= route(relay_func_sel, ind);
			// Inclusive 5 Hz to 100 Hz window
			phase_loss_check_active <=
				phase_loss_check_en == `DSO_CODE_01
				&& output_freq >= `DSO_PL_LO
				&& output_freq <= `DSO_PL_HI;
		end
	end

	// ----------------------------------------
	// Power-up ground fault check
	// ----------------------------------------
	// Decided one cycle after release so the setting is settled
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pon_pend_reg <= 1'b1;
			ground_fault_check_start <= 1'b0;
		end else begin
			pon_pend_reg <= 1'b0;
			ground_fault_check_start <= pon_pend_reg
				&& ground_fault_check_en == `DSO_CODE_01;
		end
	end

	// ----------------------------------------
	// Initialisation sequencer
	// ----------------------------------------
	logic do_clear;   // Trip history clear this cycle
	logic do_restore; // Default restore this cycle
	logic in_apply;

	assign in_apply = state_reg == dso_pkg::DSO_APPLY;
	assign do_clear = in_apply && (init_cfg_reg.mode == `DSO_CODE_01
		|| init_cfg_reg.mode == `DSO_CODE_03);
	assign do_restore = in_apply && (init_cfg_reg.mode == `DSO_CODE_02
		|| init_cfg_reg.mode == `DSO_CODE_03);
	assign init_busy = state_reg != dso_pkg::DSO_IDLE;
	assign init_done = state_reg == dso_pkg::DSO_SHOW
		&& show_cnt_reg == 32'h0000_0000;

	// Busy display, then return to idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= dso_pkg::DSO_IDLE;
			show_cnt_reg <= 32'h0000_0000;
		end else begin
			case (state_reg)
				dso_pkg::DSO_IDLE: begin
					if (init_trigger == `DSO_CODE_01)
						state_reg <= dso_pkg::DSO_APPLY;
				end
				dso_pkg::DSO_APPLY: begin
					state_reg <= dso_pkg::DSO_SHOW;
					show_cnt_reg <= 32'(INIT_CYC - 1);
				end
				dso_pkg::DSO_SHOW: begin
					if (show_cnt_reg == 32'h0000_0000)
						state_reg <= dso_pkg::DSO_IDLE;
					else
						show_cnt_reg <= show_cnt_reg - 32'h0000_0001;
				end
				default: state_reg <= dso_pkg::DSO_IDLE;
			endcase
		end
	end

	// Trigger only accepts 00 and 01; self-clears when done
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			init_trigger <= `DSO_CODE_00;
		else if (init_done)
			init_trigger <= `DSO_CODE_00;
		else if (wr_trg && !init_busy && hwdata[7:1] == 7'h00)
			init_trigger <= hwdata[7:0];
	end

	// Setup held only in flops, so power-up always reads mode 00
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			init_cfg_reg <= '0;
		else if (wr_cfg)
			init_cfg_reg <= hwdata[23:0];
	end

	// Calibration is outside the restore path
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			analog_span_cal <= 16'h0000;
		else if (wr_cal)
			analog_span_cal <= hwdata[15:0];
	end

	// ----------------------------------------
	// Parameters with restore
	// ----------------------------------------
	// Region bit picks the default set
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			freq_source_select <= `DSO_FSRC_DEF0;
			run_cmd_source_select <= `DSO_RSRC_DEF0;
			ground_fault_check_en <= `DSO_CHK_DEF;
			phase_loss_check_en <= `DSO_CHK_DEF;
		end else if (do_restore) begin
			freq_source_select <= init_cfg_reg.region[0]
				? `DSO_FSRC_DEF1 : `DSO_FSRC_DEF0;
			run_cmd_source_select <= init_cfg_reg.region[0]
				? `DSO_RSRC_DEF1 : `DSO_RSRC_DEF0;
			ground_fault_check_en <= `DSO_CHK_DEF;
			phase_loss_check_en <= `DSO_CHK_DEF;
		end else begin
			if (wr_src) begin
				freq_source_select <= hwdata[7:0];
				run_cmd_source_select <= hwdata[15:8];
			end
			if (wr_chk) begin
				ground_fault_check_en <= hwdata[7:0];
				phase_loss_check_en <= hwdata[15:8];
			end
		end
	end

	// Terminal settings restored only for target 00
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			output_terminal_func_sel <= `DSO_TERM_DEF;
			relay_func_sel <= `DSO_RELAY_DEF;
		end else if (do_restore
			&& init_cfg_reg.target == `DSO_CODE_00) begin
			output_terminal_func_sel <= `DSO_TERM_DEF;
			relay_func_sel <= `DSO_RELAY_DEF;
		end else if (wr_out) begin
			output_terminal_func_sel <= hwdata[7:0];
			relay_func_sel <= hwdata[15:8];
		end
	end

	// ----------------------------------------
	// Trip history and lifetime timers
	// ----------------------------------------
	// A trip in the clearing cycle is kept, so count is one
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			trip_cnt_reg <= 16'h0000;
		else if (do_clear)
			trip_cnt_reg <= {15'h0000, trip_event};
		else if (trip_event && trip_cnt_reg != 16'hFFFF)
			trip_cnt_reg <= trip_cnt_reg + 16'h0001;
	end

	assign tick = tick_cnt_reg == 32'(TICK_CYC - 1);

	// Timers have no path from the sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tick_cnt_reg <= 32'h0000_0000;
			run_time_reg <= 32'h0000_0000;
			pon_time_reg <= 32'h0000_0000;
		end else begin
			tick_cnt_reg <= tick ? 32'h0000_0000
				: tick_cnt_reg + 32'h0000_0001;
			if (tick) begin
				pon_time_reg <= pon_time_reg + 32'h0000_0001;
				if (run_active)
					run_time_reg <= run_time_reg + 32'h0000_0001;
			end
		end
	end

	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	logic [2:0] ev; // Done, ground check, second motor on
	assign ev = {sm_sync_reg && !sm_prev_reg,
		ground_fault_check_start, init_done};

	// Set wins over a write-one clear
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_stat_reg <= 3'b000;
			irq_mask_reg <= 3'b000;
		end else begin
			irq_stat_reg <= (irq_stat_reg
				& ~(wr_stat ? hwdata[2:0] : 3'b000)) | ev;
			if (wr_mask)
				irq_mask_reg <= hwdata[2:0];
		end
	end

	assign irq = |(irq_stat_reg & irq_mask_reg);

endmodule

`default_nettype wire

//--- verif/dso_term_probe.sv
// Terminal probe: far-side equipment reading the drive's output terminals
`timescale 1ns/1ns
`default_nettype none

// ----------------------------------------
// Samples both terminals once per clock
// ----------------------------------------
module dso_term_probe (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic       term_out,
	input  wire logic       relay_out,
	output logic      [1:0] seen
);
	// Registered like a real input stage; bit1 relay, bit0 terminal
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seen <= 2'b00;
		end else begin
			seen <= {relay_out, term_out};
		end
	end
endmodule

`default_nettype wire

//--- verif/dso_status_properties.sv
// Port-level checker of the drive status block
`include "dso_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module dso_status_props #(
	parameter int INIT_CYC = 20,
	parameter int TICK_CYC = 10
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	input  wire logic        hreadyout,
	input  wire logic        hresp,
	input  wire logic        second_motor_sel_pin,
	input  wire logic [15:0] output_freq,
	input  wire logic        freq_ref_source_ind,
	input  wire logic        run_cmd_source_ind,
	input  wire logic        second_motor_active_ind,
	input  wire logic        ground_fault_check_start,
	input  wire logic        phase_loss_check_active,
	input  wire logic        init_busy
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// ----------------------------------------
	// Helper counters
	// ----------------------------------------
	logic [1:0]  since_rst; // Edges since release, saturating
	logic [31:0] busy_run;  // Busy cycles seen so far in a run

	// Saturates so the power-on pulse is pinned to one edge only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			since_rst <= 2'd0;
		end else if (since_rst != 2'd3) begin
			since_rst <= since_rst + 2'd1;
		end
	end

	// Length of the current busy stretch
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_run <= 32'h0000_0000;
		end else begin
			busy_run <= init_busy ? busy_run + 32'h0000_0001 : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Sequences
	// ----------------------------------------
	// Pin held long enough to cross two sync flops and the output flop
	sequence s_pin_on;
		second_motor_sel_pin [*4];
	endsequence
	sequence s_pin_off;
		!second_motor_sel_pin [*4];
	endsequence
	sequence s_busy_end;
		$fell(init_busy);
	endsequence

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus answer not ready or not okay");
	a_rdata_hold: assert property
		(!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
		else $error("read data moved without a read");
	a_pin_on: assert property (s_pin_on |-> second_motor_active_ind)
		else $error("second motor indication missing");
	a_pin_off: assert property (s_pin_off |-> !second_motor_active_ind)
		else $error("second motor indication stuck");
	a_ind_blocked: assert property (second_motor_active_ind |->
		!freq_ref_source_ind && !run_cmd_source_ind)
		else $error("source indication during second motor");
	a_gf_once: assert property (ground_fault_check_start |->
		since_rst == 2'd1)
		else $error("ground fault pulse off its edge");
	a_pl_window: assert property (phase_loss_check_active |->
		$past(output_freq) >= `DSO_PL_LO && $past(output_freq) <= `DSO_PL_HI)
		else $error("phase loss check outside window");
	a_busy_len: assert property (s_busy_end |-> busy_run == INIT_CYC + 1)
		else $error("busy length wrong");
	a_busy_bound: assert property (init_busy |-> busy_run <= INIT_CYC)
		else $error("busy overran");
endmodule

`default_nettype wire

//--- verif/tb_top.sv
// Self-checking testbench of the drive status block
`include "dso_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

bind dso_status_init dso_status_props #(.INIT_CYC(INIT_CYC),
	.TICK_CYC(TICK_CYC)) dso_status_props_inst (.hclk, .hresetn, .hsel,
	.htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp,
	.second_motor_sel_pin, .output_freq, .freq_ref_source_ind,
	.run_cmd_source_ind, .second_motor_active_ind,
	.ground_fault_check_start, .phase_loss_check_active, .init_busy);

module tb_top;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int INIT_CYC = 20; // Short busy display for simulation
	localparam int TICK_CYC = 10; // Ten cycles count as one second
	logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [15:0] output_freq;
	logic        second_motor_sel_pin, run_active, trip_event;
	logic        freq_ref_source_ind, run_cmd_source_ind, term_out;
	logic        second_motor_active_ind, relay_out, irq, init_busy;
	logic        ground_fault_check_start, phase_loss_check_active;
	logic [1:0]  seen;   // Terminal levels as the probe read them
	int          error_cnt, checked;
	assign hready = hreadyout; // Single slave drives the bus ready

	dso_status_init #(.INIT_CYC(INIT_CYC), .TICK_CYC(TICK_CYC))
		dso_status_init_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
		.hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp,
		.second_motor_sel_pin, .output_freq, .run_active, .trip_event,
		.freq_ref_source_ind, .run_cmd_source_ind, .second_motor_active_ind,
		.term_out, .relay_out, .ground_fault_check_start,
		.phase_loss_check_active, .init_busy, .irq);
	dso_term_probe dso_term_probe_inst (.hclk, .hresetn, .term_out,
		.relay_out, .seen);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chb(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// One single word transfer; waits on ready, no fixed latency assumed
	task automatic ahb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge hclk);
		while (hready !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		ahb(1'b1, a, d, r);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		ahb(1'b0, a, 32'h0000_0000, r);
		chk(r, e);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// Reset values, masked power-on event, read-only and unmapped places
	task automatic t_reset;
		rdc(`DSO_SRC_SEL_OFF, 32'h0000_0202);
		rdc(`DSO_CHK_EN_OFF, 32'h0000_0101);
		rdc(`DSO_INIT_CFG_OFF, 32'h0000_0000);
		rdc(`DSO_INIT_TRG_OFF, 32'h0000_0000);
		rdc(`DSO_IRQ_STAT_OFF, 32'h0000_0002);
		chb(irq, 1'b0);
		wr(`DSO_IRQ_STAT_OFF, 32'h0000_0002);
		rdc(`DSO_IRQ_STAT_OFF, 32'h0000_0000);
		wr(`DSO_TRIP_CNT_OFF, 32'h0000_00FF);
		rdc(`DSO_TRIP_CNT_OFF, 32'h0000_0000);
		rdc(8'h40, 32'h0000_0000);
	endtask
	// Selector codes 00 to 03; only code 2 lights the indications
	task automatic t_src;
		for (int c = 0; c < 4; c++) begin
			wr(`DSO_SRC_SEL_OFF, {16'h0000, c[7:0], c[7:0]});
			tick(3);
			chb(freq_ref_source_ind, c == 2);
			chb(run_cmd_source_ind, c == 2);
		end
	endtask
	// Second motor pin overrides source indications and routes to relay
	task automatic t_second;
		wr(`DSO_SRC_SEL_OFF, 32'h0000_0202);
		wr(`DSO_OUT_SEL_OFF, 32'h0000_3C3A);
		tick(3);
		chb(seen[0], 1'b1);
		second_motor_sel_pin <= 1'b1;
		tick(6);
		chb(second_motor_active_ind, 1'b1);
		chb(freq_ref_source_ind, 1'b0);
		chb(run_cmd_source_ind, 1'b0);
		chb(seen[1], 1'b1);
		second_motor_sel_pin <= 1'b0;
		tick(6);
		chb(seen[1], 1'b0);
		chb(seen[0], 1'b1);
	endtask
	// Window edges both sides, then the enable turned off and on
	task automatic t_phase;
		logic [15:0] f[4] = '{16'd499, 16'd500, 16'd10000, 16'd10001};
		for (int i = 0; i < 4; i++) begin
			output_freq <= f[i];
			tick(3);
			chb(phase_loss_check_active, i == 1 || i == 2);
		end
		output_freq <= 16'd5000;
		wr(`DSO_CHK_EN_OFF, 32'h0000_0001);
		tick(3);
		chb(phase_loss_check_active, 1'b0);
		wr(`DSO_CHK_EN_OFF, 32'h0000_0101);
		tick(3);
		chb(phase_loss_check_active, 1'b1);
	endtask
	// All four modes; target, region, calibration and timers kept
	task automatic t_init;
		logic [31:0] cfg[4] = '{32'h0001_0103, 32'h0000_0002,
			32'h0000_0001, 32'h0000_0000};
		logic [31:0] src[4] = '{32'h0000_0100, 32'h0000_0202, 0, 0};
		logic [31:0] outs[4] = '{32'h0000_3C3A, 0, 32'h0000_3C3A,
			32'h0000_3C3A};
		logic [31:0] trips[4] = '{0, 32'h0000_0001, 0, 32'h0000_0001};
		logic [31:0] t0, t1;
		int          n;
		wr(`DSO_SPAN_CAL_OFF, 32'h0000_1234);
		wr(`DSO_IRQ_MASK_OFF, 32'h0000_0001);
		run_active <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(`DSO_SRC_SEL_OFF, 32'h0000_0000);
			wr(`DSO_OUT_SEL_OFF, 32'h0000_3C3A);
			wr(`DSO_INIT_CFG_OFF, cfg[i]);
			trip_event <= 1'b1;
			tick(1);
			trip_event <= 1'b0;
			tick(12);
			ahb(1'b0, `DSO_RUN_TIME_OFF, 32'h0000_0000, t0);
			wr(`DSO_INIT_TRG_OFF, 32'h0000_0001);
			n = 0;
			while (init_busy !== 1'b1 && n < 5) begin
				tick(1);
				n++;
			end
			chb(init_busy, 1'b1);
			n = 0;
			while (init_busy !== 1'b0 && n < 100) begin
				tick(1);
				n++;
			end
			tick(1);
			chb(init_busy, 1'b0);
			chb(irq, 1'b1);
			rdc(`DSO_SRC_SEL_OFF, src[i]);
			rdc(`DSO_OUT_SEL_OFF, outs[i]);
			rdc(`DSO_TRIP_CNT_OFF, trips[i]);
			rdc(`DSO_INIT_TRG_OFF, 32'h0000_0000);
			rdc(`DSO_INIT_CFG_OFF, cfg[i]);
			rdc(`DSO_SPAN_CAL_OFF, 32'h0000_1234);
			ahb(1'b0, `DSO_RUN_TIME_OFF, 32'h0000_0000, t1);
			chb(t1 > t0, 1'b1);
			wr(`DSO_IRQ_STAT_OFF, 32'h0000_0001);
			tick(1);
			chb(irq, 1'b0);
		end
		ahb(1'b0, `DSO_PON_TIME_OFF, 32'h0000_0000, t1);
		chb(t1 != 0, 1'b1);
		// Trigger 00 is no action; codes above 01 are refused
		wr(`DSO_INIT_TRG_OFF, 32'h0000_0000);
		tick(3);
		chb(init_busy, 1'b0);
		wr(`DSO_INIT_TRG_OFF, 32'h0000_0002);
		rdc(`DSO_INIT_TRG_OFF, 32'h0000_0000);
		chb(init_busy, 1'b0);
	endtask

	// ----------------------------------------
	// Verdict, clock, watchdog and main flow
	// ----------------------------------------
	task automatic conclude;
		$display("errors=%0d checks=%0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end
	// Whole run needs a few hundred cycles; this is ample headroom
	initial begin
		tick(20000);
		error_cnt++;
		conclude();
	end
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		output_freq = 16'h0000;
		second_motor_sel_pin = 1'b0;
		run_active = 1'b0;
		trip_event = 1'b0;
		error_cnt = 0;
		checked = 0;
		tick(20);
		hresetn <= 1'b1;
		t_reset();
		t_src();
		t_second();
		t_phase();
		t_init();
		conclude();
	end
endmodule

`default_nettype wire
